//--- hdl/dft_pkg.sv
// Shared constants and types for the device frame transport
package dft_pkg;

  // Frame type codes carried in the low byte of the first dword
  localparam logic [7:0] FT_REG_H2D = 8'h27;
  localparam logic [7:0] FT_REG_D2H = 8'h34;
  localparam logic [7:0] FT_DMA_ACT = 8'h39;
  localparam logic [7:0] FT_DMA_SETUP = 8'h41;
  localparam logic [7:0] FT_DATA = 8'h46;
  localparam logic [7:0] FT_BIST = 8'h58;
  localparam logic [7:0] FT_PIO_SETUP = 8'h5F;
  localparam logic [7:0] FT_SET_BITS = 8'hA1;

  // Field positions in the first dword
  localparam int TYPE_LSB = 0;
  localparam int DIR_BIT = 13;

  // Frame lengths in dwords
  localparam logic [2:0] LEN_REG = 3'h5;
  localparam logic [2:0] LEN_SET_BITS = 3'h2;
  localparam logic [2:0] LEN_PIO = 3'h5;
  localparam int BUF_WORDS = 5;

  // Retry ceiling and FIFO shape
  localparam logic [3:0] MAX_RETRY = 4'h3;
  localparam logic [3:0] RETRY_RST = 4'h0;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W = 32;

  // Handoff and route one-hot bit positions
  localparam int HO_DMA_ACT = 0;
  localparam int HO_DMA_SETUP = 1;
  localparam int HO_DATA_IN = 2;
  localparam int HO_BIST = 3;
  localparam int RT_CMD = 0;
  localparam int RT_DATA_OUT = 1;
  localparam int RT_DMA_SETUP = 2;
  localparam int RT_BIST = 3;

  typedef enum logic [2:0] {
    KIND_REG,
    KIND_SET_BITS,
    KIND_PIO,
    KIND_DMA_ACT,
    KIND_DMA_SETUP,
    KIND_DATA,
    KIND_BIST
  } dft_kind_t;

  typedef enum logic [3:0] {
    transport_idle_state,
    frame_type_check_state,
    register_frame_build_state,
    set_bits_frame_build_state,
    pio_setup_build_state,
    tx_status_wait_state,
    dma_activate_tx_state,
    dma_setup_tx_state,
    data_in_tx_state,
    bist_tx_state,
    command_receive_state,
    data_out_receive_state,
    dma_setup_receive_state,
    bist_receive_state
  } dft_state_t;

endpackage : dft_pkg

//--- hdl/dft_fifo.sv
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dft_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != FULL_CNT);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction : bump

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Never more than DEPTH words held
  a_fifo_bound: assert property (@(posedge sys_clk) disable iff (rst)
    cnt_reg <= FULL_CNT) else $error("fifo count overflow");
endmodule : dft_fifo
`default_nettype wire

//--- hdl/dft_transport.sv
// Device side frame transport dispatcher and control-frame transmitter
// How it works
// - Idle waits for an application request or an incoming frame start.
// - Register frame request from idle enters the register build state.
// - Set-bits frame request from idle enters the set-bits build state.
// - PIO setup request from idle enters the PIO setup build state.
// - DMA activate request hands control to its own transmit process.
// - DMA setup request hands control to its own transmit process.
// - Data frame request hands control to the data transmit process.
// - Self-test request hands control to the self-test transmit process.
// - Incoming frame start in idle enters the frame type check.
// - Host register frame routes to command receive.
// - Host data frame routes to data-out receive.
// - DMA setup frame routes to DMA setup receive.
// - Self-test frame routes to self-test receive.
// - Unknown type or illegal link transition returns to idle.
// - Register build assembles the frame, raises pending, hands it over.
// - Set-bits build assembles the frame, raises pending, hands it over.
// - PIO build assembles the frame, raises pending, hands it over.
// - Exactly one data frame follows PIO setup, direction from its flag.
// - After the last dword, signal done and enter status wait.
// - Status wait waits for ending status and handles errors.
// - Good ending status returns to idle.
// - Bad ending status reports to link and retransmits the frame, up to MAX_RETRY times; past that, it flags retry fail and returns to idle.
`timescale 1ns/1ps
`default_nettype none
module dft_transport (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic app_req_valid,
  output logic app_req_ready,
  input wire dft_pkg::dft_kind_t app_req_kind,
  input wire logic app_pio_dir,
  input wire logic app_wr_valid,
  output logic app_wr_ready,
  input wire logic [dft_pkg::WORD_W-1:0] app_wr_data,
  output logic app_done,
  output logic app_retry_fail,
  output logic [3:0] tx_handoff,
  output logic [3:0] rx_route,
  input wire logic sub_done,
  output logic pio_follow,
  output logic pio_follow_dir,
  output logic link_tx_req,
  output logic link_tx_valid,
  input wire logic link_tx_ready,
  output logic [dft_pkg::WORD_W-1:0] link_tx_data,
  output logic link_tx_last,
  output logic link_tx_done,
  input wire logic link_stat_valid,
  input wire logic link_stat_err,
  output logic link_err_report,
  input wire logic link_illegal,
  input wire logic link_rx_start,
  input wire logic [7:0] link_rx_type
);
  import dft_pkg::*;

  dft_state_t state_reg;
  dft_kind_t kind_reg;
  logic [WORD_W-1:0] buf_reg [BUF_WORDS];
  logic [2:0] idx_reg;
  logic filled_reg;
  logic dir_reg;
  logic [3:0] retry_reg;
  logic [7:0] rx_type_reg;
  logic done_reg;
  logic fail_reg;
  logic [3:0] handoff_reg;
  logic [3:0] route_reg;
  logic tx_done_reg;
  logic err_rep_reg;
  logic follow_reg;
  logic follow_dir_reg;
  logic in_build;
  logic fill_pop;
  logic send_hs;
  logic send_last;
  logic [2:0] len;
  logic stat_ok;
  logic stat_bad;
  logic retry_more;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic idle_req;

  function automatic logic [7:0] type_code(input dft_kind_t k);
    unique case (k)
      KIND_REG: type_code = FT_REG_D2H;
      KIND_SET_BITS: type_code = FT_SET_BITS;
      KIND_PIO: type_code = FT_PIO_SETUP;
      KIND_DMA_ACT: type_code = FT_DMA_ACT;
      KIND_DMA_SETUP: type_code = FT_DMA_SETUP;
      KIND_DATA: type_code = FT_DATA;
      KIND_BIST: type_code = FT_BIST;
    endcase
  endfunction : type_code

  function automatic logic [2:0] frame_len(input dft_kind_t k);
    frame_len = (k == KIND_SET_BITS) ? LEN_SET_BITS :
                (k == KIND_PIO) ? LEN_PIO : LEN_REG;
  endfunction : frame_len

  // Application words queue here so the application can run ahead
  dft_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(app_wr_valid),
    .in_ready(app_wr_ready),
    .in_data(app_wr_data),
    .out_valid(fifo_valid),
    .out_ready(fill_pop),
    .out_data(fifo_data)
  );

  assign in_build = (state_reg == register_frame_build_state) ||
                    (state_reg == set_bits_frame_build_state) ||
                    (state_reg == pio_setup_build_state);
  assign len = frame_len(kind_reg);
  // Fill only on first attempt; retries replay the held copy
  assign fill_pop = in_build && !filled_reg && !link_illegal;
  assign link_tx_req = in_build;
  assign link_tx_valid = in_build && filled_reg;
  assign link_tx_data = buf_reg[idx_reg];
  assign link_tx_last = link_tx_valid && (idx_reg == len - 3'h1);
  assign send_hs = link_tx_valid && link_tx_ready && !link_illegal;
  assign send_last = send_hs && link_tx_last;
  assign app_req_ready = (state_reg == transport_idle_state) &&
                         !link_rx_start;
  assign idle_req = app_req_valid && app_req_ready;
  assign stat_ok = (state_reg == tx_status_wait_state) &&
                   link_stat_valid && !link_stat_err;
  assign stat_bad = (state_reg == tx_status_wait_state) &&
                    link_stat_valid && link_stat_err;
  assign retry_more = (retry_reg < MAX_RETRY);

  assign app_done = done_reg;
  assign app_retry_fail = fail_reg;
  assign tx_handoff = handoff_reg;
  assign rx_route = route_reg;
  assign link_tx_done = tx_done_reg;
  assign link_err_report = err_rep_reg;
  assign pio_follow = follow_reg;
  assign pio_follow_dir = follow_dir_reg;

  // Dispatcher; incoming frames win over requests since the host
  // cannot be held off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= transport_idle_state;
    end else if (link_illegal &&
                 state_reg != transport_idle_state) begin
      state_reg <= transport_idle_state;
    end else begin
      unique case (state_reg)
        transport_idle_state: begin
          if (link_rx_start) begin
            state_reg <= frame_type_check_state;
          end else if (app_req_valid) begin
            unique case (app_req_kind)
              KIND_REG: state_reg <= register_frame_build_state;
              KIND_SET_BITS: state_reg <= set_bits_frame_build_state;
              KIND_PIO: state_reg <= pio_setup_build_state;
              KIND_DMA_ACT: state_reg <= dma_activate_tx_state;
              KIND_DMA_SETUP: state_reg <= dma_setup_tx_state;
              KIND_DATA: state_reg <= data_in_tx_state;
              KIND_BIST: state_reg <= bist_tx_state;
            endcase
          end
        end
        frame_type_check_state: begin
          unique case (rx_type_reg)
            FT_REG_H2D: state_reg <= command_receive_state;
            FT_DATA: state_reg <= data_out_receive_state;
            FT_DMA_SETUP: state_reg <= dma_setup_receive_state;
            FT_BIST: state_reg <= bist_receive_state;
            default: state_reg <= transport_idle_state;
          endcase
        end
        register_frame_build_state,
        set_bits_frame_build_state,
        pio_setup_build_state: begin
          if (send_last) begin
            state_reg <= tx_status_wait_state;
          end
        end
        tx_status_wait_state: begin
          if (stat_ok) begin
            state_reg <= transport_idle_state;
          end else if (stat_bad && !retry_more) begin
            state_reg <= transport_idle_state;
          end else if (stat_bad) begin
            unique case (kind_reg)
              KIND_SET_BITS: state_reg <= set_bits_frame_build_state;
              KIND_PIO: state_reg <= pio_setup_build_state;
              default: state_reg <= register_frame_build_state;
            endcase
          end
        end
        default: begin
          // Handed-off and receive processes report back with sub_done
          if (sub_done) begin
            state_reg <= transport_idle_state;
          end
        end
      endcase
    end
  end

  // Request and incoming type capture
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      kind_reg <= KIND_REG;
      dir_reg <= 1'b0;
      rx_type_reg <= 8'h00;
    end else begin
      if (idle_req) begin
        kind_reg <= app_req_kind;
        dir_reg <= app_pio_dir;
      end
      if (app_req_ready == 1'b0 &&
          state_reg == transport_idle_state && link_rx_start) begin
        rx_type_reg <= link_rx_type;
      end
    end
  end

  // Frame assembly: type byte and direction flag forced by the transport
  always_ff @(posedge sys_clk) begin
    if (fill_pop && fifo_valid) begin
      buf_reg[idx_reg] <= fifo_data;
      if (idx_reg == 3'h0) begin
        buf_reg[0][TYPE_LSB +: 8] <= type_code(kind_reg);
        if (kind_reg == KIND_PIO) begin
          buf_reg[0][DIR_BIT] <= dir_reg;
        end
      end
    end
  end

  // Word index and fill flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idx_reg <= 3'h0;
      filled_reg <= 1'b0;
    end else if (idle_req || !in_build) begin
      idx_reg <= 3'h0;
      if (idle_req) begin
        filled_reg <= 1'b0;
      end
    end else if (fill_pop && fifo_valid) begin
      if (idx_reg == len - 3'h1) begin
        idx_reg <= 3'h0;
        filled_reg <= 1'b1;
      end else begin
        idx_reg <= idx_reg + 3'h1;
      end
    end else if (send_hs) begin
      idx_reg <= send_last ? 3'h0 : idx_reg + 3'h1;
    end
  end

  // Retry counting; a fresh request restarts the budget
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      retry_reg <= RETRY_RST;
    end else if (idle_req) begin
      retry_reg <= RETRY_RST;
    end else if (stat_bad && retry_more) begin
      retry_reg <= retry_reg + 4'h1;
    end
  end

  // One-cycle event outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_done_reg <= 1'b0;
      err_rep_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      tx_done_reg <= send_last;
      err_rep_reg <= stat_bad;
      done_reg <= stat_ok;
      fail_reg <= stat_bad && !retry_more;
    end
  end

  // Handoff and route strobes toward the other processes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      handoff_reg <= 4'h0;
      route_reg <= 4'h0;
    end else begin
      handoff_reg <= 4'h0;
      route_reg <= 4'h0;
      if (idle_req && !link_illegal) begin
        handoff_reg[HO_DMA_ACT] <= (app_req_kind == KIND_DMA_ACT);
        handoff_reg[HO_DMA_SETUP] <= (app_req_kind == KIND_DMA_SETUP);
        handoff_reg[HO_DATA_IN] <= (app_req_kind == KIND_DATA);
        handoff_reg[HO_BIST] <= (app_req_kind == KIND_BIST);
      end
      if (state_reg == frame_type_check_state && !link_illegal) begin
        route_reg[RT_CMD] <= (rx_type_reg == FT_REG_H2D);
        route_reg[RT_DATA_OUT] <= (rx_type_reg == FT_DATA);
        route_reg[RT_DMA_SETUP] <= (rx_type_reg == FT_DMA_SETUP);
        route_reg[RT_BIST] <= (rx_type_reg == FT_BIST);
      end
    end
  end

  // Pending PIO data frame; a new setup wins over the data-frame clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      follow_reg <= 1'b0;
      follow_dir_reg <= 1'b0;
    end else if (stat_ok && kind_reg == KIND_PIO) begin
      follow_reg <= 1'b1;
      follow_dir_reg <= dir_reg;
    end else if (handoff_reg[HO_DATA_IN] || route_reg[RT_DATA_OUT]) begin
      follow_reg <= 1'b0;
    end
  end

  a_idle_wait: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == transport_idle_state && !app_req_valid && !link_rx_start
    |=> state_reg == transport_idle_state)
    else $error("idle left without cause");
  a_reg_dispatch: assert property (@(posedge sys_clk) disable iff (rst)
    idle_req && app_req_kind == KIND_REG && !link_illegal
    |=> state_reg == register_frame_build_state)
    else $error("register request not dispatched");
  a_bits_dispatch: assert property (@(posedge sys_clk) disable iff (rst)
    idle_req && app_req_kind == KIND_SET_BITS && !link_illegal
    |=> state_reg == set_bits_frame_build_state)
    else $error("set bits request not dispatched");
  a_pio_dispatch: assert property (@(posedge sys_clk) disable iff (rst)
    idle_req && app_req_kind == KIND_PIO && !link_illegal
    |=> state_reg == pio_setup_build_state)
    else $error("pio request not dispatched");
  a_handoff_pulse: assert property (@(posedge sys_clk) disable iff (rst)
    idle_req && app_req_kind > KIND_PIO && !link_illegal
    |=> $onehot(tx_handoff) ##1 tx_handoff == 4'h0)
    else $error("handoff strobe wrong");
  a_rx_check: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == transport_idle_state && link_rx_start
    |=> state_reg == frame_type_check_state)
    else $error("incoming frame not checked");
  a_cmd_route: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == frame_type_check_state && !link_illegal &&
    rx_type_reg == FT_REG_H2D |=> rx_route[RT_CMD] &&
    state_reg == command_receive_state)
    else $error("command frame misrouted");
  a_rx_others: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == frame_type_check_state && !link_illegal &&
    (rx_type_reg == FT_DMA_SETUP || rx_type_reg == FT_BIST)
    |=> $onehot(rx_route))
    else $error("receive route missing");
  a_unknown_idle: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == frame_type_check_state && rx_type_reg != FT_REG_H2D &&
    rx_type_reg != FT_DATA && rx_type_reg != FT_DMA_SETUP &&
    rx_type_reg != FT_BIST |=> state_reg == transport_idle_state
    && rx_route == 4'h0)
    else $error("unknown type not dropped");
  a_done_status: assert property (@(posedge sys_clk) disable iff (rst)
    send_last |=> link_tx_done && state_reg == tx_status_wait_state)
    else $error("done strobe or status wait missing");
  a_ok_idle: assert property (@(posedge sys_clk) disable iff (rst)
    stat_ok |=> state_reg == transport_idle_state && app_done)
    else $error("good status not closed");
  a_err_retry: assert property (@(posedge sys_clk) disable iff (rst)
    stat_bad && retry_more && !link_illegal
    |=> link_err_report && in_build && idx_reg == 3'h0)
    else $error("error retry missing");
  a_retry_cap: assert property (@(posedge sys_clk) disable iff (rst)
    stat_bad && !retry_more |=> app_retry_fail &&
    state_reg == transport_idle_state)
    else $error("retry ceiling ignored");
  a_pio_follow: assert property (@(posedge sys_clk) disable iff (rst)
    stat_ok && kind_reg == KIND_PIO
    |=> pio_follow && pio_follow_dir == $past(dir_reg))
    else $error("pio follow not raised");
  a_pend_frame: assert property (@(posedge sys_clk) disable iff (rst)
    link_tx_valid && idx_reg == 3'h0 |-> link_tx_req &&
    link_tx_data[TYPE_LSB +: 8] == type_code(kind_reg))
    else $error("frame type byte wrong");

  c_reg_ok: cover property (@(posedge sys_clk) disable iff (rst)
    state_reg == register_frame_build_state ##[1:40] app_done);
  c_retry: cover property (@(posedge sys_clk) disable iff (rst)
    stat_bad ##[1:40] stat_ok);
  c_fail: cover property (@(posedge sys_clk) disable iff (rst)
    app_retry_fail);
  c_cmd_rx: cover property (@(posedge sys_clk) disable iff (rst)
    rx_route[RT_CMD]);
endmodule : dft_transport
`default_nettype wire

//--- test/dft_link_model.sv
// Link layer model: takes the dword stream, returns ending status
`timescale 1ns/1ps
`default_nettype none
module dft_link_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_tx_done,
  input wire logic ld,
  input wire logic [2:0] nerr,
  output logic link_tx_ready,
  output logic link_stat_valid,
  output logic link_stat_err
);
  logic [2:0] left;
  logic [1:0] dly;
  // Stalls at random; status err line shows noise when not valid
  always @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      link_tx_ready <= 1'b0;
      link_stat_valid <= 1'b0;
      link_stat_err <= 1'b0;
      left <= 3'h0;
      dly <= 2'h0;
    end else begin
      link_tx_ready <= ($urandom_range(3, 0) != 0);
      link_stat_valid <= (dly == 2'h1);
      link_stat_err <= (dly == 2'h1) ? (left != 3'h0) : 1'($urandom);
      if (ld) begin
        left <= nerr;
      end else if (dly == 2'h1 && left != 3'h0) begin
        left <= left - 3'h1;
      end
      if (link_tx_done) begin
        dly <= 2'h3;
      end else if (dly != 2'h0) begin
        dly <= dly - 2'h1;
      end
    end
  end
endmodule : dft_link_model
`default_nettype wire

//--- test/tb_device_fis_transport_fsm.sv
// Self-checking bench for the device frame transport
`timescale 1ns/1ps
`default_nettype none
module tb_device_fis_transport_fsm;
  import dft_pkg::*;
  logic sys_clk = 0, rst = 1, rq_v = 0, pio_d = 0, wr_v = 0, sub_done = 0;
  logic ill = 0, rx_s = 0, ld = 0;
  logic [7:0] rx_t = 8'h00;
  logic [2:0] nerr = 3'h0;
  logic [31:0] wr_d = 32'h0000_0000;
  dft_kind_t kind = KIND_REG;
  logic rq_r, wr_r, done, fail, fol, fol_d, tq, tv, tr, tl, tdn;
  logic sv, se, erep;
  logic [3:0] ho, rt;
  logic [31:0] td;
  logic [32:0] wq[$];
  logic [7:0] eq[$];
  int error_cnt = 0, checks = 0, cyc = 0, nrep = 0, ndn = 0;
  dft_transport i_dut (.sys_clk(sys_clk), .rst(rst), .app_req_valid(rq_v),
    .app_req_ready(rq_r), .app_req_kind(kind), .app_pio_dir(pio_d),
    .app_wr_valid(wr_v), .app_wr_ready(wr_r), .app_wr_data(wr_d),
    .app_done(done), .app_retry_fail(fail), .tx_handoff(ho), .rx_route(rt),
    .sub_done(sub_done), .pio_follow(fol), .pio_follow_dir(fol_d),
    .link_tx_req(tq), .link_tx_valid(tv), .link_tx_ready(tr),
    .link_tx_data(td), .link_tx_last(tl), .link_tx_done(tdn),
    .link_stat_valid(sv), .link_stat_err(se), .link_err_report(erep),
    .link_illegal(ill), .link_rx_start(rx_s), .link_rx_type(rx_t));
  dft_link_model i_link (.sys_clk(sys_clk), .rst(rst), .link_tx_done(tdn),
    .ld(ld), .nerr(nerr), .link_tx_ready(tr), .link_stat_valid(sv),
    .link_stat_err(se));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [32:0] exp, logic [32:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Scoreboard side: oldest note against each observed result
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
    if (erep === 1'b1) nrep++;
    if (tdn === 1'b1) ndn++;
    if (tv === 1'b1 && tr === 1'b1) begin
      chk("tx_req", 1, tq);
      if (wq.size() == 0) chk("tx_extra", 0, 1);
      else chk("tx_word", wq.pop_front(), {tl, td});
    end
    if (rst === 1'b0 && (ho !== 4'h0 || rt !== 4'h0)) begin
      if (eq.size() == 0) chk("route_extra", 0, {ho, rt});
      else chk("route", eq.pop_front(), {ho, rt});
    end
  end
  task automatic req(dft_kind_t k, logic d);
    @(negedge sys_clk);
    rq_v = 1;
    kind = k;
    pio_d = d;
    do @(posedge sys_clk); while (rq_r !== 1'b1);
    @(negedge sys_clk);
    rq_v = 0;
  endtask : req
  task automatic push(logic [31:0] r[5], int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      wr_v = 1;
      wr_d = r[i];
      do @(posedge sys_clk); while (wr_r !== 1'b1);
    end
    @(negedge sys_clk);
    wr_v = 0;
  endtask : push
  // One control frame; errs bad statuses, fail when ceiling is passed
  task automatic frame(dft_kind_t k, logic d, int errs, logic fl);
    logic [31:0] r[5];
    logic [31:0] e[5];
    int n;
    n = (k == KIND_SET_BITS) ? 2 : 5;
    for (int i = 0; i < 5; i++) r[i] = $urandom;
    e = r;
    e[0][7:0] = (k == KIND_REG) ? FT_REG_D2H :
      (k == KIND_SET_BITS) ? FT_SET_BITS : FT_PIO_SETUP;
    if (k == KIND_PIO) e[0][DIR_BIT] = d;
    repeat (fl ? 4 : errs + 1)
      for (int i = 0; i < n; i++) wq.push_back({i == n - 1, e[i]});
    @(negedge sys_clk);
    ld = 1;
    nerr = 3'(errs);
    repeat (2) @(negedge sys_clk);
    ld = 0;
    nrep = 0;
    ndn = 0;
    fork
      push(r, n);
      req(k, d);
    join
    for (int t = 0; t < 400; t++) begin
      @(posedge sys_clk);
      if (done === 1'b1 || fail === 1'b1) break;
    end
    chk("retry_fail", fl, fail);
    chk("done", !fl, done);
    @(negedge sys_clk);
    chk("words_left", 0, wq.size());
    chk("err_reports", errs, nrep);
    chk("tx_dones", fl ? 4 : errs + 1, ndn);
    chk("idle_ready", 1, rq_r);
  endtask : frame
  task automatic hand(dft_kind_t k, int b);
    eq.push_back(8'(1 << (b + 4)));
    req(k, 0);
    repeat (3) @(negedge sys_clk);
    sub_done = 1;
    @(negedge sys_clk);
    sub_done = 0;
    @(negedge sys_clk);
    chk("handoff_idle", 1, rq_r);
  endtask : hand
  task automatic rx(logic [7:0] t, int b);
    if (b >= 0) eq.push_back(8'(1 << b));
    @(negedge sys_clk);
    rx_s = 1;
    rx_t = t;
    @(negedge sys_clk);
    rx_s = 0;
    rx_t = ~t;
    repeat (3) @(negedge sys_clk);
    if (b >= 0) chk("rx_busy", 0, rq_r);
    sub_done = 1;
    @(negedge sys_clk);
    sub_done = 0;
    @(negedge sys_clk);
    chk("rx_idle", 1, rq_r);
  endtask : rx
  initial begin
    logic [31:0] r[5];
    void'($urandom(64));
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 0;
    frame(KIND_REG, 0, 0, 0);
    frame(KIND_SET_BITS, 0, 1, 0);
    frame(KIND_PIO, 1, 2, 0);
    chk("pio_follow", 2'b11, {fol, fol_d});
    hand(KIND_DATA, HO_DATA_IN);
    chk("pio_clear", 0, fol);
    hand(KIND_DMA_ACT, HO_DMA_ACT);
    hand(KIND_DMA_SETUP, HO_DMA_SETUP);
    hand(KIND_BIST, HO_BIST);
    frame(KIND_REG, 0, 4, 1);
    rx(FT_REG_H2D, RT_CMD);
    rx(FT_DATA, RT_DATA_OUT);
    rx(FT_DMA_SETUP, RT_DMA_SETUP);
    rx(FT_BIST, RT_BIST);
    rx(FT_REG_D2H, -1);
    for (int i = 0; i < 5; i++) r[i] = $urandom;
    fork
      push(r, 2);
      begin
        req(KIND_REG, 0);
        ill = 1;
        @(negedge sys_clk);
        ill = 0;
      end
    join
    chk("illegal_idle", 1, rq_r);
    chk("eq_left", 0, eq.size());
    complete_run();
  end
endmodule : tb_device_fis_transport_fsm
`default_nettype wire
